// ==== trd_pkg.sv ====
// Shared constants and types of the tag reader timing and control block.
package trd_pkg;

  // ****************************************************************
  // Clock and carrier
  // ****************************************************************
  localparam int CLK_HZ       = 40_000_000;
  localparam int CLK_NS       = 25;
  localparam int CARRIER_HZ   = 125_000;
  localparam int CARRIER_DIV  = CLK_HZ / CARRIER_HZ;
  localparam int CAR_HALF     = CARRIER_DIV / 2;
  localparam int CNT_W        = 9;
  localparam int STEP_PER_REV = 32;
  localparam int STEP_CYC     = CARRIER_DIV / STEP_PER_REV;
  localparam int STEP_W       = 4;
  localparam int STEP_IDX_ZERO  = 7;
  localparam int STEP_IDX_RESET = 8;
  localparam int STEP_IDX_MAX   = 15;
  localparam int EVAL_TMO_CYC   = 2 * CARRIER_DIV;

  // ****************************************************************
  // Reference capacitor preset timing
  // ****************************************************************
  localparam int PRESET_ON_DLY_NS     = 256_000;
  localparam int PRESET_LEN_NS        = 128_000;
  localparam int PRESET_SETTLE_DLY_NS = 518_000;
  localparam int PRESET_ON_DLY_CYC     = (PRESET_ON_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRESET_LEN_CYC        = (PRESET_LEN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRESET_SETTLE_DLY_CYC = (PRESET_SETTLE_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_W = 15;

  // ****************************************************************
  // Demodulated data stream
  // ****************************************************************
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  localparam int BITS_W = 3;

  typedef enum logic [1:0] {MODE_ONE_WIRE, MODE_TWO_WIRE, MODE_MCU} trd_mode_t;
  typedef enum logic [1:0] {ST_SETTLE, ST_EVAL, ST_RUN, ST_STANDBY} trd_fsm_t;
  typedef enum logic [1:0] {PR_IDLE, PR_WAIT, PR_ON} trd_pre_t;

  typedef struct packed {
    logic             a;
    logic             b;
    logic             oe;
  } trd_drive_t;

  typedef struct packed {
    trd_fsm_t           fsm;
    logic [CNT_W-1:0]   cnt;
    logic [CNT_W:0]     eval_cnt;
    logic [STEP_W-1:0]  step;
    logic               rd_prev;
    logic               drv_en;
    trd_drive_t         drv;
    trd_pre_t           pre;
    logic [PRE_W-1:0]   pre_cnt;
    logic [FIFO_W-1:0]  shreg;
    logic [BITS_W-1:0]  bits;
    logic               pend;
    logic [FIFO_W-1:0]  pend_data;
    logic               dropped;
    logic               demod;
    logic               tx_shut;
    logic               tx_seen_off;
  } trd_state_t;

endpackage : trd_pkg

// ==== trd_fifo.sv ====
// Parameterised first-in first-out buffer with valid/ready on both sides.
`timescale 1ns/1ps
module trd_fifo
  import trd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 level;
  } trd_fifo_state_t;

  trd_fifo_state_t s_q;
  trd_fifo_state_t s_d;
  logic            push;
  logic            pop;

  assign in_ready  = (s_q.level != (AW+1)'(DEPTH));
  assign out_valid = (s_q.level != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   s_d.level = s_q.level + 1'b1;
      2'b01:   s_d.level = s_q.level - 1'b1;
      default: s_d.level = s_q.level;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : trd_fifo

// ==== trd_top.sv ====
// Carrier, antenna driver, sampling phase, preset and transmitter restart control.
`timescale 1ns/1ps

module trd_top
  import trd_pkg::*;
#(
  parameter int ON_DLY_CYC     = PRESET_ON_DLY_CYC,
  parameter int LEN_CYC        = PRESET_LEN_CYC,
  parameter int SETTLE_DLY_CYC = PRESET_SETTLE_DLY_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              low_voltage_reset_pin_n,
  input  wire logic              config_select_a,
  input  wire logic              config_select_b,
  input  wire logic              modulation_input,
  input  wire logic              standby_req,
  input  wire logic              osc_settled,
  input  wire logic              rd_phase_in,
  input  wire logic              rd_compare_in,
  input  wire logic              tx_in,
  input  wire logic              overtemp,
  output logic                   antenna_drive_a_o,
  output logic                   antenna_drive_a_oe,
  output logic                   antenna_drive_b_o,
  output logic                   antenna_drive_b_oe,
  output logic                   comparator_ref_cap,
  output logic [STEP_W-1:0]      sample_step,
  output logic                   demod_out,
  output logic                   diag_tx_enable,
  output logic                   sample_dropped,
  output trd_mode_t              mode,
  output logic                   data_valid,
  input  wire logic              data_ready,
  output logic [FIFO_W-1:0]      data_out
);

  // ****************************************************************
  // Reset, mode decode and state
  // ****************************************************************
  logic       rst;
  trd_state_t s_q;
  trd_state_t s_d;
  logic       fifo_ready;
  logic       standby_cmd;
  logic       tx_cmd;
  logic [CNT_W:0] sample_pt;

  // Either reset source loads the reset state without waiting for a clock edge.
  assign rst = sys_rst || !low_voltage_reset_pin_n;

  always_comb begin
    if (config_select_a) begin
      mode = MODE_MCU;
    end else if (config_select_b) begin
      mode = MODE_TWO_WIRE;
    end else begin
      mode = MODE_ONE_WIRE;
    end
  end

  // In the MCU mode the second select pin doubles as the standby control.
  assign standby_cmd = (mode == MODE_MCU) ? !config_select_b : standby_req;
  // The transmitter command comes from the demodulator except in the MCU mode.
  assign tx_cmd = (mode == MODE_MCU) ? tx_in : s_q.demod;

  // Sample instant relative to the falling edge of driver a at half period.
  always_comb begin
    sample_pt = (CNT_W+1)'(CAR_HALF + CARRIER_DIV - STEP_IDX_ZERO * STEP_CYC)
              + (CNT_W+1)'(s_q.step) * (CNT_W+1)'(STEP_CYC);
    if (sample_pt >= (CNT_W+1)'(CARRIER_DIV)) begin
      sample_pt = sample_pt - (CNT_W+1)'(CARRIER_DIV);
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    int d;
    int idx;
    logic sample_now;
    d = 0;
    idx = 0;
    sample_now = 1'b0;
    s_d = s_q;
    s_d.dropped = 1'b0;
    s_d.rd_prev = rd_phase_in;
    // The oscillator stops in standby, so the carrier counter freezes.
    if (s_q.fsm != ST_STANDBY) begin
      s_d.cnt = (s_q.cnt == CNT_W'(CARRIER_DIV-1)) ? '0 : s_q.cnt + 1'b1;
    end
    case (s_q.fsm)
      ST_SETTLE: begin
        s_d.drv_en = 1'b1;
        if (osc_settled) begin
          s_d.fsm = ST_EVAL;
          s_d.eval_cnt = '0;
          s_d.pre = PR_WAIT;
          s_d.pre_cnt = PRE_W'(SETTLE_DLY_CYC - 1);
        end
      end
      ST_EVAL: begin
        s_d.eval_cnt = s_q.eval_cnt + 1'b1;
        if (rd_phase_in && !s_q.rd_prev) begin
          d = (s_q.cnt >= CNT_W'(CAR_HALF)) ? int'(s_q.cnt) - CARRIER_DIV : int'(s_q.cnt);
          idx = STEP_IDX_RESET + d / STEP_CYC;
          if (idx < 0) begin
            idx = 0;
          end else if (idx > STEP_IDX_MAX) begin
            idx = STEP_IDX_MAX;
          end
          s_d.step = STEP_W'(idx);
          s_d.fsm = ST_RUN;
        end else if (s_q.eval_cnt == (CNT_W+1)'(EVAL_TMO_CYC)) begin
          // No antenna edge seen: keep the previous step rather than guess.
          s_d.fsm = ST_RUN;
        end
      end
      ST_RUN: begin
        s_d.drv_en = modulation_input;
        if (modulation_input && !s_q.drv_en) begin
          s_d.pre = PR_WAIT;
          s_d.pre_cnt = PRE_W'(ON_DLY_CYC - 1);
        end
        if (standby_cmd) begin
          s_d.fsm = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (!standby_cmd) begin
          s_d.fsm = ST_SETTLE;
        end
      end
      default: s_d.fsm = ST_SETTLE;
    endcase

    // Antenna drivers follow the carrier while on and float while off; in standby outside the MCU mode they drive a low and b high.
    if (s_q.fsm == ST_STANDBY) begin
      if (mode != MODE_MCU) begin
        s_d.drv = '{a: 1'b0, b: 1'b1, oe: 1'b1};
      end
    end else if (s_d.drv_en) begin
      s_d.drv.a = (s_d.cnt < CNT_W'(CAR_HALF));
      s_d.drv.b = !s_d.drv.a;
      s_d.drv.oe = 1'b1;
    end else begin
      s_d.drv.oe = 1'b0;
    end

    // Reference capacitor preset: a delay then a fixed-length pulse.
    case (s_q.pre)
      PR_IDLE: ;
      PR_WAIT: begin
        if (s_q.pre_cnt == '0) begin
          s_d.pre = PR_ON;
          s_d.pre_cnt = PRE_W'(LEN_CYC - 1);
        end else begin
          s_d.pre_cnt = s_q.pre_cnt - 1'b1;
        end
      end
      PR_ON: begin
        if (s_q.pre_cnt == '0) begin
          s_d.pre = PR_IDLE;
        end else begin
          s_d.pre_cnt = s_q.pre_cnt - 1'b1;
        end
      end
      default: s_d.pre = PR_IDLE;
    endcase
    // Stopping the oscillator abandons any preset in flight.
    if (s_q.fsm == ST_STANDBY) begin
      s_d.pre = PR_IDLE;
    end

    // One sample per carrier period resolves bit rates up to 8 kHz easily.
    if (s_q.pend && fifo_ready) begin
      s_d.pend = 1'b0;
    end
    if (s_q.fsm == ST_RUN && s_q.drv_en && s_q.cnt == sample_pt[CNT_W-1:0]) begin
      sample_now = 1'b1;
    end
    if (sample_now) begin
      s_d.demod = rd_compare_in;
      if (s_q.pend && !fifo_ready && s_q.bits == BITS_W'(FIFO_W-1)) begin
        // The byte cannot complete while the previous one waits: drop this sample.
        s_d.dropped = 1'b1;
      end else begin
        s_d.shreg = {s_q.shreg[FIFO_W-2:0], rd_compare_in};
        s_d.bits = s_q.bits + 1'b1;
        if (s_q.bits == BITS_W'(FIFO_W-1)) begin
          s_d.pend = 1'b1;
          s_d.pend_data = {s_q.shreg[FIFO_W-2:0], rd_compare_in};
        end
      end
    end

    // Transmitter restart needs cool-down plus an off then on command.
    if (overtemp) begin
      s_d.tx_shut = 1'b1;
      s_d.tx_seen_off = 1'b0;
    end else if (s_q.tx_shut) begin
      if (!tx_cmd) begin
        s_d.tx_seen_off = 1'b1;
      end else if (s_q.tx_seen_off) begin
        s_d.tx_shut = 1'b0;
        s_d.tx_seen_off = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{fsm: ST_SETTLE, step: STEP_W'(STEP_IDX_RESET), drv_en: 1'b1,
               drv: '{a: 1'b1, b: 1'b0, oe: 1'b1}, pre: PR_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs and data buffer
  // ****************************************************************
  assign antenna_drive_a_o  = s_q.drv.a;
  assign antenna_drive_b_o  = s_q.drv.b;
  assign antenna_drive_a_oe = s_q.drv.oe;
  assign antenna_drive_b_oe = s_q.drv.oe;
  assign comparator_ref_cap = (s_q.pre == PR_ON);
  assign sample_step        = s_q.step;
  assign demod_out          = s_q.demod;
  assign diag_tx_enable     = !s_q.tx_shut && (mode != MODE_MCU || s_q.fsm != ST_STANDBY);
  assign sample_dropped     = s_q.dropped;

  trd_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (s_q.pend),
    .in_ready  (fifo_ready),
    .in_data   (s_q.pend_data),
    .out_valid (data_valid),
    .out_ready (data_ready),
    .out_data  (data_out)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [15:0] since_q;
  logic        kind_q;
  logic [15:0] len_q;
  logic        evaluated_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      since_q <= '0;
      kind_q <= 1'b0;
      len_q <= '0;
      evaluated_q <= 1'b0;
    end else begin
      since_q <= (since_q == 16'hffff) ? since_q : since_q + 1'b1;
      if (s_q.fsm == ST_SETTLE && osc_settled) begin
        since_q <= 16'h0001;
        kind_q <= 1'b1;
      end else if (s_q.fsm == ST_RUN && modulation_input && !s_q.drv_en) begin
        since_q <= 16'h0001;
        kind_q <= 1'b0;
      end
      len_q <= comparator_ref_cap ? len_q + 1'b1 : '0;
      if (s_q.fsm == ST_EVAL && s_d.fsm == ST_RUN) begin
        evaluated_q <= 1'b1;
      end
    end
  end

  a_sample_point: assert property (
    (s_q.fsm == ST_RUN && s_q.drv_en && s_q.cnt == sample_pt[CNT_W-1:0])
      |=> demod_out == $past(rd_compare_in)) else $error("sample not taken");
  a_step_reset: assert property (!evaluated_q |-> s_q.step == STEP_W'(STEP_IDX_RESET))
    else $error("step not at reset value");
  a_step_hold: assert property ((s_q.fsm == ST_RUN && $past(s_q.fsm) == ST_RUN)
    |-> $stable(s_q.step)) else $error("step changed outside evaluation");
  a_preset_delay: assert property ($rose(comparator_ref_cap)
    |-> $past(since_q) == 16'(kind_q ? SETTLE_DLY_CYC : ON_DLY_CYC))
    else $error("preset delay wrong");
  a_preset_length: assert property ($fell(comparator_ref_cap) && $past(s_q.fsm) != ST_STANDBY
    |-> len_q == 16'(LEN_CYC)) else $error("preset length wrong");
  a_drive_off_hiz: assert property (s_q.fsm == ST_RUN && !modulation_input && !standby_cmd
    |=> !antenna_drive_a_oe && !antenna_drive_b_oe) else $error("drivers not floating");
  a_carrier_phase: assert property ((s_q.fsm != ST_STANDBY && s_d.drv_en)
    |=> antenna_drive_a_o == (s_q.cnt < CNT_W'(CAR_HALF)) && antenna_drive_b_o != antenna_drive_a_o)
    else $error("carrier phase wrong");
  a_tx_restart: assert property ($fell(s_q.tx_shut)
    |-> $past(s_q.tx_seen_off) && $past(tx_cmd) && !$past(overtemp)) else $error("bad restart");
  a_mode_decode: assert property (
    mode == (config_select_a ? MODE_MCU : (config_select_b ? MODE_TWO_WIRE : MODE_ONE_WIRE)))
    else $error("mode decode wrong");
  a_standby_bus: assert property (
    s_q.fsm == ST_STANDBY && $past(s_q.fsm) == ST_STANDBY && mode != MODE_MCU
      && $past(mode) != MODE_MCU
      |-> !antenna_drive_a_o && antenna_drive_b_o && antenna_drive_a_oe) else $error("standby drive");

  c_preset: cover property ($rose(comparator_ref_cap));
  c_eval_done: cover property (s_q.fsm == ST_EVAL ##1 s_q.fsm == ST_RUN);
  c_standby: cover property (s_q.fsm == ST_RUN ##1 s_q.fsm == ST_STANDBY);
  c_stall: cover property (s_q.pend && !fifo_ready);

endmodule : trd_top

// ==== trd_tag_model.sv ====
// Behavioural model of the passive transponder coupled to the antenna.
`timescale 1ns/1ps
module trd_tag_model (
  input  wire logic       ref_clk,
  input  wire logic       antenna_drive_a_o,
  input  wire logic       antenna_drive_a_oe,
  input  wire logic [8:0] phase_dly,
  input  wire logic       resp_level,
  output logic            rd_phase_in,
  output logic            rd_compare_in
);
  logic [319:0] hist_q   = '0;
  logic         toggle_q = 1'b0;

  // Only a driven field reaches the antenna tap; a floating driver gives no carrier.
  always @(posedge ref_clk) begin
    hist_q   <= {hist_q[318:0], antenna_drive_a_o & antenna_drive_a_oe};
    toggle_q <= ~toggle_q;
  end

  assign rd_phase_in   = hist_q[phase_dly];
  // An unpowered tag leaves the demodulator input undefined, so it wanders.
  assign rd_compare_in = antenna_drive_a_oe ? resp_level : toggle_q;
endmodule : trd_tag_model

// ==== trd_top_tb_top.sv ====
// Self-checking testbench of the tag reader timing and control block.
`timescale 1ns/1ps
module trd_top_tb_top
  import trd_pkg::*;
;
  localparam int ON  = 40;
  localparam int LEN = 20;
  localparam int SET = 60;

  logic              ref_clk = 1'b0;
  logic              sys_rst, low_voltage_reset_pin_n, config_select_a, config_select_b;
  logic              modulation_input, standby_req, osc_settled, rd_phase_in, rd_compare_in;
  logic              tx_in, overtemp, antenna_drive_a_o, antenna_drive_a_oe;
  logic              antenna_drive_b_o, antenna_drive_b_oe, comparator_ref_cap;
  logic [STEP_W-1:0] sample_step;
  logic              demod_out, diag_tx_enable, sample_dropped, data_valid, data_ready;
  trd_mode_t         mode;
  logic [FIFO_W-1:0] data_out;
  logic [8:0]        phase_dly;
  logic              resp_level;
  int                errors = 0;
  int                checked = 0;

  trd_top #(.ON_DLY_CYC(ON), .LEN_CYC(LEN), .SETTLE_DLY_CYC(SET)) dut (
    .ref_clk, .sys_rst, .low_voltage_reset_pin_n, .config_select_a, .config_select_b,
    .modulation_input, .standby_req, .osc_settled, .rd_phase_in, .rd_compare_in,
    .tx_in, .overtemp, .antenna_drive_a_o, .antenna_drive_a_oe, .antenna_drive_b_o,
    .antenna_drive_b_oe, .comparator_ref_cap, .sample_step, .demod_out, .diag_tx_enable,
    .sample_dropped, .mode, .data_valid, .data_ready, .data_out
  );

  trd_tag_model tag (
    .ref_clk, .antenna_drive_a_o, .antenna_drive_a_oe, .phase_dly, .resp_level,
    .rd_phase_in, .rd_compare_in
  );

  always #12.5 ref_clk = ~ref_clk;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_rng

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : cyc

  function automatic logic [3:0] exp_step(input int dly);
    int d;
    d = dly + 1;
    if (d > 159) d = d - 320;
    d = 8 + d / 10;
    if (d < 0) d = 0;
    if (d > 15) d = 15;
    return d[3:0];
  endfunction : exp_step

  // Counting starts at the input change, so the trigger edge itself is one count.
  task automatic preset_chk(input int dly);
    int n;
    n = 0;
    while (comparator_ref_cap !== 1'b1 && n < 3000) begin cyc(1); n++; end
    chk_rng("preset delay", dly, dly + 2, n);
    n = 0;
    while (comparator_ref_cap === 1'b1 && n < 3000) begin cyc(1); n++; end
    chk_rng("preset length", LEN, LEN, n);
  endtask : preset_chk

  task automatic reset_state_chk();
    chk("drive a oe", 1, antenna_drive_a_oe);
    chk("drive b oe", 1, antenna_drive_b_oe);
    chk("drive a", 1, antenna_drive_a_o);
    chk("preset", 0, comparator_ref_cap);
    chk("step", 8, sample_step);
  endtask : reset_state_chk

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      {config_select_a, config_select_b} = i[1:0];
      #1;
      chk("mode", (i > 1) ? MODE_MCU : ((i == 1) ? MODE_TWO_WIRE : MODE_ONE_WIRE), mode);
    end
    {config_select_a, config_select_b} = 2'b00;
    repeat (2) @(posedge ref_clk);
    #2;
    reset_state_chk();
    sys_rst = 1'b0;
    cyc(3);
    chk("step before eval", 8, sample_step);
  endtask : t_reset

  task automatic t_settle();
    osc_settled = 1'b1;
    preset_chk(SET);
    cyc(700);
    chk("step evaluated", exp_step(34), sample_step);
  endtask : t_settle

  task automatic t_carrier();
    int n;
    n = 0;
    while (antenna_drive_a_o !== 1'b0 && n < 400) begin cyc(1); n++; end
    n = 0;
    while (antenna_drive_a_o !== 1'b1 && n < 400) begin cyc(1); n++; end
    n = 0;
    while (antenna_drive_a_o === 1'b1 && n < 400) begin cyc(1); n++; end
    chk_rng("carrier high", CAR_HALF, CAR_HALF, n);
    n = 0;
    while (antenna_drive_a_o === 1'b0 && n < 400) begin cyc(1); n++; end
    chk_rng("carrier low", CAR_HALF, CAR_HALF, n);
  endtask : t_carrier

  task automatic t_write();
    modulation_input = 1'b0;
    cyc(3);
    chk("drive a off", 0, antenna_drive_a_oe);
    chk("drive b off", 0, antenna_drive_b_oe);
    modulation_input = 1'b1;
    preset_chk(ON);
  endtask : t_write

  task automatic t_stream();
    int n;
    logic seen;
    seen = 1'b0;
    n = 0;
    data_ready = 1'b0;
    repeat (11 * 8 * CARRIER_DIV) begin
      cyc(1);
      if (sample_dropped === 1'b1) seen = 1'b1;
    end
    chk("sample dropped", 1, seen);
    data_ready = 1'b1;
    repeat (40) begin
      if (data_valid === 1'b1) begin
        n++;
        chk("data byte", 8'hff, data_out);
      end
      cyc(1);
    end
    chk_rng("bytes drained", FIFO_D, FIFO_D + 1, n);
    chk("drained valid", 0, data_valid);
    resp_level = 1'b0;
    cyc(2 * CARRIER_DIV);
    chk("demod low", 0, demod_out);
    resp_level = 1'b1;
    cyc(2 * CARRIER_DIV);
    chk("demod high", 1, demod_out);
  endtask : t_stream

  task automatic t_standby();
    int dl [2] = '{264, 150};
    logic [3:0] prev;
    prev = exp_step(34);
    foreach (dl[i]) begin
      phase_dly = dl[i][8:0];
      cyc(700);
      chk("step kept", prev, sample_step);
      standby_req = 1'b1;
      osc_settled = 1'b0;
      cyc(3);
      chk("standby drive a", 0, antenna_drive_a_o);
      chk("standby drive b", 1, antenna_drive_b_o);
      chk("standby a oe", 1, antenna_drive_a_oe);
      chk("standby b oe", 1, antenna_drive_b_oe);
      standby_req = 1'b0;
      // The tap delay line runs on while the carrier stops, so it is refilled before settling.
      cyc(CARRIER_DIV + 20);
      osc_settled = 1'b1;
      preset_chk(SET);
      cyc(400);
      prev = exp_step(dl[i]);
      chk("step after wake", prev, sample_step);
    end
  endtask : t_standby

  task automatic t_overtemp();
    logic frozen;
    {config_select_a, config_select_b} = 2'b11;
    tx_in = 1'b1;
    cyc(3);
    chk("tx enabled", 1, diag_tx_enable);
    overtemp = 1'b1;
    cyc(3);
    chk("tx shut", 0, diag_tx_enable);
    overtemp = 1'b0;
    cyc(3);
    chk("tx cooled no cmd", 0, diag_tx_enable);
    tx_in = 1'b0;
    cyc(3);
    chk("tx cmd off", 0, diag_tx_enable);
    tx_in = 1'b1;
    cyc(3);
    chk("tx restarted", 1, diag_tx_enable);
    config_select_b = 1'b0;
    cyc(3);
    frozen = antenna_drive_a_o;
    chk("mcu standby tx", 0, diag_tx_enable);
    cyc(CAR_HALF);
    chk("mcu standby frozen", frozen, antenna_drive_a_o);
    chk("mcu standby oe", 1, antenna_drive_a_oe);
    config_select_b = 1'b1;
    cyc(3);
    chk("mcu wake tx", 1, diag_tx_enable);
  endtask : t_overtemp

  task automatic t_lvr();
    low_voltage_reset_pin_n = 1'b0;
    #3;
    reset_state_chk();
    chk("reset valid", 0, data_valid);
    cyc(2);
    low_voltage_reset_pin_n = 1'b1;
    cyc(2);
  endtask : t_lvr

  initial begin
    sys_rst                 = 1'b1;
    low_voltage_reset_pin_n = 1'b1;
    config_select_a         = 1'b0;
    config_select_b         = 1'b0;
    modulation_input        = 1'b1;
    standby_req             = 1'b0;
    osc_settled             = 1'b0;
    tx_in                   = 1'b0;
    overtemp                = 1'b0;
    data_ready              = 1'b1;
    phase_dly               = 9'h022;
    resp_level              = 1'b1;
    t_reset();
    t_settle();
    t_carrier();
    t_write();
    t_stream();
    t_standby();
    t_overtemp();
    t_lvr();
    finish_test();
  end

  // The scenarios need about 34000 cycles; the watchdog allows more than twice that.
  initial begin
    repeat (80000) @(posedge ref_clk);
    errors++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end
endmodule : trd_top_tb_top
